/* design/sssr_regs.sv */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps

module sssr_regs
  import sssr_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sssr_straps_t straps,
  input wire logic [3:0] rx_lane_a_align_cycles,
  input wire logic [3:0] rx_lane_b_align_cycles,
  input wire logic [SSSR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SSSR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================================
  // State.
  // ==========================================================================
  typedef struct packed {
    sssr_phase_t phase;
    logic [15:0] skew;
    logic [15:0] sts1;
    logic [15:0] sts2;
    logic aw_got;
    logic w_got;
    logic [SSSR_ADDR_W-1:0] awaddr;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sssr_state_t;

  sssr_state_t st_q;
  sssr_state_t st_d;
  logic [15:0] sts1_img;
  logic [15:0] sts2_img;
  logic wr_map;
  logic rd_map;

  // Strap images built from the pin levels per package option.
  always_comb begin
    sts1_img = 16'h0000;
    sts2_img = 16'h0000;
    sts1_img[SSSR_S1_MIRROR] = straps.mirror_on;
    sts1_img[SSSR_S1_DOWNSHIFT] = straps.downshift_on;
    sts1_img[SSSR_S1_MAC_IF_OFF] = straps.pin_reduced_mac_if_off;
    sts1_img[SSSR_S1_AUTOX_OFF] = straps.pin_auto_crossover_off;
    sts1_img[SSSR_S1_FORCED_X] = straps.pin_forced_crossover;
    sts1_img[SSSR_S1_HALF_DUP] = straps.pin_half_duplex;
    sts1_img[SSSR_S1_ANEG_OFF] = straps.pin_autoneg_off;
    sts2_img[SSSR_S2_QLL] = straps.pin_quick_link_loss_on;
    if (LARGE_PKG) begin
      sts1_img[SSSR_S1_REFCLK_OFF] = straps.pin_refclk_output_off;
      sts1_img[SSSR_S1_SPEED_LSB +: 2] =
        straps.pin_speed_choice_wide;
      sts1_img[SSSR_S1_ADDR_LSB +: 5] =
        straps.pin_mgmt_port_address;
    end else begin
      sts1_img[SSSR_S1_SPEED_LSB] = straps.pin_speed_choice_wide[0];
      sts1_img[SSSR_S1_ADDR_LSB +: 4] =
        straps.pin_mgmt_port_address[3:0];
      sts2_img[SSSR_S2_TXDLY_LSB +: 3] = straps.tx_clk_delay;
      sts2_img[SSSR_S2_RXDLY_LSB +: 3] = straps.rx_clk_delay;
    end
  end

  assign wr_map = (st_q.awaddr == SSSR_ADDR_SKEW) ||
                  (st_q.awaddr == SSSR_ADDR_STS1) ||
                  (st_q.awaddr == SSSR_ADDR_STS2);
  assign rd_map = (s_axi_araddr == SSSR_ADDR_SKEW) ||
                  (s_axi_araddr == SSSR_ADDR_STS1) ||
                  (s_axi_araddr == SSSR_ADDR_STS2);

  // ==========================================================================
  // Next state: strap latch, skew capture and the bus slave.
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    // Skew readings follow the receiver every cycle.
    st_d.skew[SSSR_SKEW_A_LSB +: 4] = rx_lane_a_align_cycles;
    st_d.skew[SSSR_SKEW_B_LSB +: 4] = rx_lane_b_align_cycles;
    unique case (st_q.phase)
      SSSR_LATCH: begin
        // First edge after reset release captures the straps once.
        st_d.sts1 = sts1_img;
        st_d.sts2 = sts2_img;
        st_d.phase = SSSR_RUN;
      end
      SSSR_RUN: begin
        st_d.phase = SSSR_RUN;
      end
      default: begin
        st_d.phase = SSSR_LATCH;
      end
    endcase

    // Write channel: address and data accepted in either order.
    st_d.awready = 1'b0;
    st_d.wready = 1'b0;
    if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid &&
        !st_q.awready) begin
      st_d.awready = 1'b1;
    end
    if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid && !st_q.wready) begin
      st_d.wready = 1'b1;
    end
    if (st_q.awready && s_axi_awvalid) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (st_q.wready && s_axi_wvalid) begin
      st_d.w_got = 1'b1;
    end
    // Data and strobes are dropped: every register here is read-only.
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = wr_map ? SSSR_RESP_OKAY : SSSR_RESP_SLVERR;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Read channel.
    st_d.arready = 1'b0;
    if (s_axi_arvalid && !st_q.rvalid && !st_q.arready) begin
      st_d.arready = 1'b1;
    end
    if (st_q.arready && s_axi_arvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = rd_map ? SSSR_RESP_OKAY : SSSR_RESP_SLVERR;
      st_d.rdata = 32'h0000_0000;
      if (s_axi_araddr == SSSR_ADDR_SKEW) begin
        st_d.rdata[15:0] = st_q.skew;
      end else if (s_axi_araddr == SSSR_ADDR_STS1) begin
        st_d.rdata[15:0] = st_q.sts1;
      end else if (s_axi_araddr == SSSR_ADDR_STS2) begin
        st_d.rdata[15:0] = st_q.sts2;
      end
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  // Register the whole state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.phase <= SSSR_LATCH;
      st_q.skew <= SSSR_SKEW_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  a_skew_lane_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> st_q.skew[3:0] == $past(rx_lane_a_align_cycles))
    else $error("lane A skew does not follow input");
  a_skew_lane_b: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> st_q.skew[7:4] == $past(rx_lane_b_align_cycles))
    else $error("lane B skew does not follow input");
  a_skew_high_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.skew[15:8] == 8'h00)
    else $error("skew reserved bits nonzero");
  a_strap_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=> st_q.sts1 == $past(sts1_img) &&
    st_q.sts2 == $past(sts2_img))
    else $error("straps not captured at release");
  a_strap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_RUN |=> $stable(st_q.sts1) && $stable(st_q.sts2))
    else $error("strap image changed after capture");
  a_sts1_bit11: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.sts1[11] == 1'b0)
    else $error("status one bit 11 nonzero");
  a_sts2_resv: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.sts2[15:11] == 5'h00 && st_q.sts2[9:7] == 3'h0 &&
    st_q.sts2[3] == 1'b0)
    else $error("status two reserved bits nonzero");
  a_small_pkg_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !LARGE_PKG |-> st_q.sts1[6] == 1'b0 && st_q.sts1[4] == 1'b0 &&
    st_q.sts1[13] == 1'b0)
    else $error("small package reserved bits nonzero");
  a_large_pkg_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    LARGE_PKG |-> st_q.sts2[6:0] == 7'h00)
    else $error("large package delay bits nonzero");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.aw_got && st_q.w_got && !st_q.bvalid |=> s_axi_bvalid)
    else $error("write answer missing");

  // ==========================================================================
  // Write channel checks: one-cycle readies, held response, no side effect.
  // ==========================================================================
  a_awready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awready |=> !s_axi_awready)
    else $error("awready high two cycles");
  a_wready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_wready |=> !s_axi_wready)
    else $error("wready high two cycles");
  a_write_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
    else $error("write response code changed");
  a_bvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_write_okay: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.aw_got && st_q.w_got && !st_q.bvalid && wr_map |=>
    s_axi_bresp == SSSR_RESP_OKAY)
    else $error("mapped write not answered okay");
  a_write_error: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.aw_got && st_q.w_got && !st_q.bvalid && !wr_map |=>
    s_axi_bresp == SSSR_RESP_SLVERR)
    else $error("unmapped write not answered with error");
  a_write_no_effect: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_RUN && s_axi_wvalid && s_axi_wready |=>
    $stable(st_q.sts1) && $stable(st_q.sts2))
    else $error("write changed a strap image");
  a_awaddr_take: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready |=> st_q.awaddr == $past(s_axi_awaddr))
    else $error("write address not captured");

  // ==========================================================================
  // Read channel checks: one-cycle arready, held data, decoded contents.
  // ==========================================================================
  a_arready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arready |=> !s_axi_arready)
    else $error("arready high two cycles");
  a_read_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while pending");
  a_rvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half nonzero");
  a_read_error: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && !rd_map |=>
    s_axi_rresp == SSSR_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not answered with error");
  a_read_skew: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SSSR_ADDR_SKEW |=>
    s_axi_rdata[15:0] == $past(st_q.skew))
    else $error("skew read returned wrong word");
  a_read_sts1: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SSSR_ADDR_STS1 |=>
    s_axi_rdata[15:0] == $past(st_q.sts1))
    else $error("status one read returned wrong word");
  a_read_sts2: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SSSR_ADDR_STS2 |=>
    s_axi_rdata[15:0] == $past(st_q.sts2))
    else $error("status two read returned wrong word");

  // ==========================================================================
  // Strap capture checks: each field against the pin level at release.
  // ==========================================================================
  a_mirror_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=> st_q.sts1[15] == $past(straps.mirror_on))
    else $error("mirror strap bit wrong");
  a_downshift_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=> st_q.sts1[14] == $past(straps.downshift_on))
    else $error("downshift strap bit wrong");
  a_refclk_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    LARGE_PKG && st_q.phase == SSSR_LATCH |=>
    st_q.sts1[13] == $past(straps.pin_refclk_output_off))
    else $error("clock output strap bit wrong");
  a_mac_if_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=>
    st_q.sts1[12] == $past(straps.pin_reduced_mac_if_off))
    else $error("MAC interface strap bit wrong");
  a_autox_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=>
    st_q.sts1[10] == $past(straps.pin_auto_crossover_off))
    else $error("auto crossover strap bit wrong");
  a_forced_x_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=>
    st_q.sts1[9] == $past(straps.pin_forced_crossover))
    else $error("forced crossover strap bit wrong");
  a_duplex_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=> st_q.sts1[8] == $past(straps.pin_half_duplex))
    else $error("duplex strap bit wrong");
  a_aneg_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=> st_q.sts1[7] == $past(straps.pin_autoneg_off))
    else $error("auto-negotiation strap bit wrong");
  a_large_speed: assert property (
    @(posedge aclk) disable iff (!aresetn)
    LARGE_PKG && st_q.phase == SSSR_LATCH |=>
    st_q.sts1[6:5] == $past(straps.pin_speed_choice_wide))
    else $error("wide speed field wrong");
  a_small_speed: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !LARGE_PKG && st_q.phase == SSSR_LATCH |=>
    st_q.sts1[5] == $past(straps.pin_speed_choice_wide[0]))
    else $error("narrow speed bit wrong");
  a_large_addr: assert property (
    @(posedge aclk) disable iff (!aresetn)
    LARGE_PKG && st_q.phase == SSSR_LATCH |=>
    st_q.sts1[4:0] == $past(straps.pin_mgmt_port_address))
    else $error("five-bit address field wrong");
  a_small_addr: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !LARGE_PKG && st_q.phase == SSSR_LATCH |=>
    st_q.sts1[3:0] == $past(straps.pin_mgmt_port_address[3:0]))
    else $error("four-bit address field wrong");
  a_quick_loss_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=>
    st_q.sts2[10] == $past(straps.pin_quick_link_loss_on))
    else $error("quick link loss strap bit wrong");
  a_small_txdly: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !LARGE_PKG && st_q.phase == SSSR_LATCH |=>
    st_q.sts2[6:4] == $past(straps.tx_clk_delay))
    else $error("transmit delay field wrong");
  a_small_rxdly: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !LARGE_PKG && st_q.phase == SSSR_LATCH |=>
    st_q.sts2[2:0] == $past(straps.rx_clk_delay))
    else $error("receive delay field wrong");
  a_phase_run: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.phase == SSSR_LATCH |=> st_q.phase == SSSR_RUN)
    else $error("capture phase did not end");

endmodule

/* pkg/sssr_pkg.sv */
package sssr_pkg;

  // ==========================================================================
  // Register map: printed offsets are indices, byte address is four times.
  // ==========================================================================
  localparam logic [7:0] SSSR_IDX_SKEW = 8'h55;
  localparam logic [7:0] SSSR_IDX_STS1 = 8'h6e;
  localparam logic [7:0] SSSR_IDX_STS2 = 8'h6f;
  localparam int SSSR_ADDR_W = 12;
  localparam logic [11:0] SSSR_ADDR_SKEW = {2'h0, SSSR_IDX_SKEW, 2'h0};
  localparam logic [11:0] SSSR_ADDR_STS1 = {2'h0, SSSR_IDX_STS1, 2'h0};
  localparam logic [11:0] SSSR_ADDR_STS2 = {2'h0, SSSR_IDX_STS2, 2'h0};
  localparam logic [15:0] SSSR_SKEW_RESET = 16'h0000;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int SSSR_SKEW_A_LSB = 0;
  localparam int SSSR_SKEW_B_LSB = 4;
  localparam int SSSR_S1_MIRROR = 15;
  localparam int SSSR_S1_DOWNSHIFT = 14;
  localparam int SSSR_S1_REFCLK_OFF = 13;
  localparam int SSSR_S1_MAC_IF_OFF = 12;
  localparam int SSSR_S1_AUTOX_OFF = 10;
  localparam int SSSR_S1_FORCED_X = 9;
  localparam int SSSR_S1_HALF_DUP = 8;
  localparam int SSSR_S1_ANEG_OFF = 7;
  localparam int SSSR_S1_SPEED_LSB = 5;
  localparam int SSSR_S1_ADDR_LSB = 0;
  localparam int SSSR_S2_QLL = 10;
  localparam int SSSR_S2_TXDLY_LSB = 4;
  localparam int SSSR_S2_RXDLY_LSB = 0;

  // AXI4-Lite response codes.
  localparam logic [1:0] SSSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSSR_RESP_SLVERR = 2'h2;

  // Strap pin levels, as they stand at the device pins.
  typedef struct packed {
    logic mirror_on;
    logic downshift_on;
    logic pin_refclk_output_off;
    logic pin_reduced_mac_if_off;
    logic pin_auto_crossover_off;
    logic pin_forced_crossover;
    logic pin_half_duplex;
    logic pin_autoneg_off;
    logic [1:0] pin_speed_choice_wide;
    logic [4:0] pin_mgmt_port_address;
    logic pin_quick_link_loss_on;
    logic [2:0] tx_clk_delay;
    logic [2:0] rx_clk_delay;
  } sssr_straps_t;

  typedef enum logic [1:0] {
    SSSR_LATCH = 2'b00,
    SSSR_RUN = 2'b01
  } sssr_phase_t;

endpackage

/* verif/strap_and_skew_status_regs_tb.sv */
`timescale 1ns/1ps

module strap_and_skew_status_regs_tb import sssr_pkg::*;;
  // ==========================================
  // Stimulus and observed signals
  // ==========================================
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  sssr_straps_t straps = '0;
  sssr_straps_t latched = '0;
  logic [3:0] lane_a = 4'h0;
  logic [3:0] lane_b = 4'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready [2];
  logic wready [2];
  logic bvalid [2];
  logic arready [2];
  logic rvalid [2];
  logic [1:0] bresp [2];
  logic [1:0] rresp [2];
  logic [31:0] rdata [2];
  int n_errors = 0;
  int num_checks = 0;
  logic [11:0] addrs [$] = '{SSSR_ADDR_SKEW, SSSR_ADDR_STS1, SSSR_ADDR_STS2,
                             12'h000, 12'h1c0, 12'hffc};

  // Clock of 4 ns period.
  always #2 aclk = ~aclk;

  // Both package layouts run side by side on one shared bus.
  for (genvar g = 0; g < 2; g++) begin : g_pkg
    sssr_regs #(.LARGE_PKG(g == 0)) uut (
      .aclk(aclk), .aresetn(aresetn), .straps(straps),
      .rx_lane_a_align_cycles(lane_a), .rx_lane_b_align_cycles(lane_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready[g]), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready[g]),
      .s_axi_bresp(bresp[g]), .s_axi_bvalid(bvalid[g]),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready[g]),
      .s_axi_rdata(rdata[g]), .s_axi_rresp(rresp[g]),
      .s_axi_rvalid(rvalid[g]), .s_axi_rready(rready));
  end

  // ==========================================
  // Reference model and checking
  // ==========================================
  function automatic logic [1:0] resp_of(input logic [11:0] a);
    if (a == SSSR_ADDR_SKEW || a == SSSR_ADDR_STS1 || a == SSSR_ADDR_STS2) begin
      return SSSR_RESP_OKAY;
    end
    return SSSR_RESP_SLVERR;
  endfunction

  // Expected word for package g (0 large, 1 small) at address a.
  function automatic logic [31:0] expect_reg(input int g, input logic [11:0] a);
    sssr_straps_t s;
    logic [15:0] v;
    s = latched;
    v = 16'h0000;
    if (a == SSSR_ADDR_SKEW) begin
      v = {8'h00, lane_b, lane_a};
    end else if (a == SSSR_ADDR_STS1) begin
      v[15:7] = {s.mirror_on, s.downshift_on,
                 (g == 0) && s.pin_refclk_output_off,
                 s.pin_reduced_mac_if_off, 1'b0, s.pin_auto_crossover_off,
                 s.pin_forced_crossover, s.pin_half_duplex, s.pin_autoneg_off};
      if (g == 0) begin
        v[6:0] = {s.pin_speed_choice_wide, s.pin_mgmt_port_address};
      end else begin
        v[6:0] = {2'h0, s.pin_speed_choice_wide[0], 1'b0,
                  s.pin_mgmt_port_address[3:0]};
      end
    end else if (a == SSSR_ADDR_STS2) begin
      v[10] = s.pin_quick_link_loss_on;
      if (g == 1) begin
        v[6:0] = {s.tx_clk_delay, 1'b0, s.rx_clk_delay};
      end
    end
    return {16'h0000, v};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A bus wait that ran out counts as a mismatch and ends the run.
  task automatic limit(input int n);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask

  // ==========================================
  // AXI4-Lite master tasks
  // ==========================================
  task automatic axi_read(input logic [11:0] a);
    int n;
    logic [31:0] sv;
    logic [31:0] ev;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready[0] !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid[0] !== 1'b1 && n < 50);
    rready <= 1'b0;
    limit(n);
    for (int g = 0; g < 2; g++) begin
      sv = rdata[g];
      ev = expect_reg(g, a);
      chk(sv & 32'hffff0000, ev & 32'hffff0000);
      chk(sv & 32'h0000f800, ev & 32'h0000f800);
      chk(sv & 32'h00000780, ev & 32'h00000780);
      chk(sv & 32'h00000070, ev & 32'h00000070);
      chk(sv & 32'h0000000f, ev & 32'h0000000f);
      chk(sv & 32'h00001470, ev & 32'h00001470);
      chk(sv & 32'h0000047f, ev & 32'h0000047f);
      chk({30'h0, rresp[g]}, {30'h0, resp_of(a)});
    end
    @(posedge aclk);
  endtask

  task automatic axi_write(input logic [11:0] a);
    int n;
    bit aw_d;
    bit w_d;
    n = 0;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= $urandom;
    wstrb <= 4'($urandom);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d) && n < 50) begin
      @(posedge aclk);
      n++;
      if (!aw_d && awready[0] === 1'b1) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready[0] === 1'b1) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid[0] !== 1'b1 && n < 50);
    bready <= 1'b0;
    limit(n);
    for (int g = 0; g < 2; g++) begin
      chk({30'h0, bresp[g]}, {30'h0, resp_of(a)});
    end
    @(posedge aclk);
  endtask

  // ==========================================
  // Main sequence: reset with new straps, then read, write, read again
  // ==========================================
  initial begin
    void'($urandom(97));
    for (int r = 0; r < 6; r++) begin
      aresetn <= 1'b0;
      straps <= sssr_straps_t'(22'($urandom));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      latched = straps;
      @(posedge aclk);
      straps <= sssr_straps_t'(22'($urandom));
      @(posedge aclk);
      foreach (addrs[i]) begin
        lane_a <= 4'($urandom);
        lane_b <= 4'($urandom);
        @(posedge aclk);
        axi_read(addrs[i]);
        axi_write(addrs[i]);
        axi_read(addrs[i]);
      end
      $display("round %0d finished", r);
    end
    wrap_up();
  end
endmodule
